// >>> nfc_pkg.sv
// Package for the NOR flash command and protect controller
package nfc_pkg;
   // Register offsets (byte addresses, word aligned)
   localparam logic [3:0] REG_CTRL_OFF = 4'h0;
   localparam logic [3:0] REG_ADDR_OFF = 4'h4;
   localparam logic [3:0] REG_DATA_OFF = 4'h8;
   localparam logic [3:0] REG_STAT_OFF = 4'hC;
   // Control register fields
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_CMD_LSB = 4;
   localparam int CTRL_TEMP_UNPROT_BIT = 8;
   // Command codes written into the control register
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_RESET = 3'h1;
   localparam logic [2:0] OP_ID_ENTER = 3'h2;
   localparam logic [2:0] OP_PROGRAM = 3'h3;
   localparam logic [2:0] OP_SECT_ERASE = 3'h4;
   localparam logic [2:0] OP_CHIP_ERASE = 3'h5;
   localparam logic [2:0] OP_RAW_WRITE = 3'h6;
   // Flash bus command bytes and unlock addresses
   localparam logic [7:0] FL_UNLOCK1 = 8'hAA;
   localparam logic [7:0] FL_UNLOCK2 = 8'h55;
   localparam logic [7:0] FL_ID_CMD = 8'h90;
   localparam logic [7:0] FL_PROG_CMD = 8'hA0;
   localparam logic [7:0] FL_ERASE_SETUP = 8'h80;
   localparam logic [7:0] FL_CHIP_ERASE = 8'h10;
   localparam logic [7:0] FL_SECT_ERASE = 8'h30;
   localparam logic [7:0] FL_RESET_CMD = 8'hF0;
   localparam logic [19:0] FL_ADDR_555 = 20'h00555;
   localparam logic [19:0] FL_ADDR_2AA = 20'h002AA;
   // Identifier readout word offsets
   localparam logic [19:0] ID_MAKER_OFF = 20'h00000;
   localparam logic [19:0] ID_DEVICE_OFF = 20'h00001;
   localparam logic [19:0] ID_PROT_OFF = 20'h00002;
   // Bus cycle phase length in clocks (100 ns each)
   localparam int PHASE_NS = 100;
   localparam int CLK_NS = 100;
   localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Flash pin group
   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [19:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
   } nfc_pins_t;
   // One flash bus cycle request to the cycle engine
   typedef struct packed {
      logic wr;
      logic [19:0] addr;
      logic [15:0] data;
   } nfc_cyc_t;
endpackage : nfc_pkg

// >>> nfc_cycle.sv
// Single asynchronous flash bus cycle generator
`timescale 1ns/100ps
module nfc_cycle
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Request side
   input wire logic req_valid_in,
   input wire nfc_pkg::nfc_cyc_t req_in,
   output logic req_ready_out,
   output logic done_out,
   output logic [15:0] rdata_out,
   // Pins
   output nfc_pkg::nfc_pins_t pins_out,
   input wire logic [15:0] dq_in
);
   import nfc_pkg::*;
   typedef enum logic [1:0] {CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b10,
                             CY_HOLD = 2'b11} nfc_cy_t;
   nfc_cy_t st_reg, st_next;
   nfc_cyc_t cur_reg, cur_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [15:0] rd_reg, rd_next;
   nfc_pins_t pin_reg, pin_next;

   assign req_ready_out = (st_reg == CY_IDLE);
   assign done_out = (st_reg == CY_HOLD) && (cnt_reg == 4'h0);
   assign rdata_out = rd_reg;
   assign pins_out = pin_reg;

   // Next state: address first, then strobe, then release
   always_comb
   begin
      st_next = st_reg;
      cur_next = cur_reg;
      cnt_next = cnt_reg;
      rd_next = rd_reg;
      pin_next = pin_reg;
      unique case (st_reg)
         CY_IDLE:
         begin
            pin_next.ce_n = 1'b1;
            pin_next.we_n = 1'b1;
            pin_next.oe_n = 1'b1;
            pin_next.dq_oe = 1'b0;
            if (req_valid_in)
            begin
               cur_next = req_in;
               pin_next.addr = req_in.addr;
               pin_next.dq_out = req_in.data;
               pin_next.dq_oe = req_in.wr;
               cnt_next = PHASE_CYC;
               st_next = CY_SETUP;
            end
         end
         CY_SETUP:
         begin
            if (cnt_reg == 4'h1)
            begin
               // Write: ce and we low with oe high; read: oe low
               pin_next.ce_n = 1'b0;
               pin_next.we_n = !cur_reg.wr;
               pin_next.oe_n = cur_reg.wr;
               cnt_next = PHASE_CYC;
               st_next = CY_STROBE;
            end
            else
               cnt_next = cnt_reg - 4'h1;
         end
         CY_STROBE:
         begin
            if (cnt_reg == 4'h1)
            begin
               // Data stays on the pins past the we rising edge
               if (!cur_reg.wr)
                  rd_next = dq_in;
               pin_next.we_n = 1'b1;
               pin_next.oe_n = 1'b1;
               pin_next.ce_n = 1'b1;
               cnt_next = 4'h0;
               st_next = CY_HOLD;
            end
            else
               cnt_next = cnt_reg - 4'h1;
         end
         CY_HOLD:
         begin
            pin_next.dq_oe = 1'b0;
            st_next = CY_IDLE;
         end
         default:
            st_next = CY_IDLE;
      endcase
   end

   // Registers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_reg <= CY_IDLE;
         cur_reg <= '0;
         cnt_reg <= 4'h0;
         rd_reg <= 16'h0000;
         pin_reg <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000,
                      dq_out: 16'h0000, dq_oe: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
         cur_reg <= cur_next;
         cnt_reg <= cnt_next;
         rd_reg <= rd_next;
         pin_reg <= pin_next;
      end
   end

   // Write strobe only falls while chip select is low and outputs off
   a_write_qualify: assert property (@(posedge clk_in) disable iff (rst_in)
      !pin_reg.we_n |-> (!pin_reg.ce_n && pin_reg.oe_n))
      else $error("write strobe low without valid qualifiers");
   a_addr_stable: assert property (@(posedge clk_in) disable iff (rst_in)
      (!pin_reg.we_n && !pin_reg.ce_n) |=> $stable(pin_reg.addr) && $stable(pin_reg.dq_out))
      else $error("address or data moved during strobe");
   a_never_both: assert property (@(posedge clk_in) disable iff (rst_in)
      !(!pin_reg.we_n && !pin_reg.oe_n))
      else $error("write and output enable low together");
   c_write_cycle: cover property (@(posedge clk_in) disable iff (rst_in)
      $fell(pin_reg.we_n));
   c_read_cycle: cover property (@(posedge clk_in) disable iff (rst_in)
      $fell(pin_reg.oe_n));
endmodule : nfc_cycle

// >>> nfc_ctrl.sv
// Host controller issuing command sequences to a parallel NOR flash
`timescale 1ns/100ps
module nfc_ctrl
(
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   // Avalon-MM slave
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   // Flash pins
   output logic FL_CE_N_OUT,
   output logic FL_WE_N_OUT,
   output logic FL_OE_N_OUT,
   output logic FL_RESET_N_OUT,
   output logic FL_RESET_ELEV_OUT,
   output logic [19:0] FL_ADDR_OUT,
   output logic [15:0] FL_DQ_OUT,
   output logic FL_DQ_OE_OUT,
   input wire logic [15:0] FL_DQ_IN
);
   import nfc_pkg::*;
   typedef enum logic [1:0] {NF_IDLE = 2'b00, NF_ISSUE = 2'b01, NF_WAIT = 2'b10}
      nfc_st_t;
   nfc_st_t st_reg, st_next;
   logic [2:0] op_reg, op_next;
   logic [2:0] step_reg, step_next;
   logic [19:0] addr_reg, addr_next;
   logic [15:0] data_reg, data_next;
   logic [15:0] rdata_reg, rdata_next;
   logic tun_reg, tun_next;
   logic err_reg, err_next;
   logic id_mode_reg, id_mode_next;
   logic done_reg, done_next;
   logic rd_ack_reg, rd_ack_next;
   logic [31:0] rdd_next;
   logic [31:0] rd_mux;
   logic busy;
   logic cyc_valid, cyc_ready, cyc_done;
   logic [15:0] cyc_rdata;
   nfc_cyc_t cyc_req;
   nfc_pins_t pins;

   // Number of flash bus cycles in each command sequence
   function automatic logic [2:0] seq_len(input logic [2:0] op);
      unique case (op)
         OP_READ, OP_RESET, OP_RAW_WRITE: seq_len = 3'h1;
         OP_ID_ENTER: seq_len = 3'h3;
         OP_PROGRAM: seq_len = 3'h4;
         OP_SECT_ERASE, OP_CHIP_ERASE: seq_len = 3'h6;
         default: seq_len = 3'h1;
      endcase
   endfunction : seq_len

   // Unlock pattern shared by all multi-cycle sequences
   function automatic nfc_cyc_t unlock_cyc(input logic [2:0] idx);
      unlock_cyc.wr = 1'b1;
      unlock_cyc.addr = idx[0] ? FL_ADDR_2AA : FL_ADDR_555;
      unlock_cyc.data = {8'h00, idx[0] ? FL_UNLOCK2 : FL_UNLOCK1};
   endfunction : unlock_cyc

   // Stall CTRL writes while busy; one wait state on every read
   assign busy = (st_reg != NF_IDLE);
   assign AVS_WAITREQUEST_OUT = (AVS_WRITE_IN && busy && (AVS_ADDRESS_IN == REG_CTRL_OFF))
                                || (AVS_READ_IN && !rd_ack_reg);

   // Cycle contents for the current step of the sequence
   always_comb
   begin
      cyc_req = unlock_cyc(step_reg);
      unique case (op_reg)
         OP_READ:
         begin
            cyc_req.wr = 1'b0; // Identifier reads land on low lane
            cyc_req.addr = addr_reg; // Sector address in upper bits
         end
         OP_RESET:
         begin
            cyc_req.addr = addr_reg; // Address is don't care
            cyc_req.data = {8'h00, FL_RESET_CMD};
         end
         OP_RAW_WRITE:
         begin
            cyc_req.addr = addr_reg;
            cyc_req.data = data_reg;
         end
         OP_ID_ENTER:
            if (step_reg == 3'h2)
               cyc_req.data = {8'h00, FL_ID_CMD}; // In-system entry
         OP_PROGRAM:
            if (step_reg == 3'h2)
               cyc_req.data = {8'h00, FL_PROG_CMD};
            else if (step_reg == 3'h3)
            begin
               cyc_req.addr = addr_reg;
               cyc_req.data = data_reg;
            end
         default:
            if (step_reg == 3'h2)
               cyc_req.data = {8'h00, FL_ERASE_SETUP};
            else if (step_reg == 3'h3)
               cyc_req = unlock_cyc(3'h0);
            else if (step_reg == 3'h4)
               cyc_req = unlock_cyc(3'h1);
            else if (step_reg == 3'h5)
            begin
               cyc_req.addr = (op_reg == OP_SECT_ERASE) ? addr_reg : FL_ADDR_555;
               cyc_req.data = {8'h00, (op_reg == OP_SECT_ERASE) ? FL_SECT_ERASE
                                                               : FL_CHIP_ERASE};
            end
      endcase
   end

   assign cyc_valid = (st_reg == NF_ISSUE);

   // Sequencer and register file next values
   always_comb
   begin
      st_next = st_reg;
      op_next = op_reg;
      step_next = step_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      rdata_next = rdata_reg;
      tun_next = tun_reg;
      err_next = err_reg;
      id_mode_next = id_mode_reg;
      done_next = done_reg;
      if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT)
      begin
         unique case (AVS_ADDRESS_IN)
            REG_ADDR_OFF: addr_next = AVS_WRITEDATA_IN[19:0];
            REG_DATA_OFF: data_next = AVS_WRITEDATA_IN[15:0];
            REG_CTRL_OFF:
            begin
               // Elevated reset level held only while bit is set
               tun_next = AVS_WRITEDATA_IN[CTRL_TEMP_UNPROT_BIT];
               if (AVS_WRITEDATA_IN[CTRL_GO_BIT])
               begin
                  op_next = AVS_WRITEDATA_IN[CTRL_CMD_LSB +: 3]; // No unprotect op
                  step_next = 3'h0;
                  done_next = 1'b0;
                  st_next = NF_ISSUE;
               end
            end
            REG_STAT_OFF: done_next = 1'b0;
            default: ;
         endcase
      end
      unique case (st_reg)
         NF_IDLE: ;
         NF_ISSUE:
            if (cyc_ready)
               st_next = NF_WAIT;
         NF_WAIT:
            if (cyc_done)
            begin
               if (op_reg == OP_READ)
               begin
                  rdata_next = cyc_rdata;
                  // Time-limit error flag seen while polling
                  if (!id_mode_reg && cyc_rdata[5])
                     err_next = 1'b1;
               end
               if (step_reg == seq_len(op_reg) - 3'h1)
               begin
                  st_next = NF_IDLE;
                  done_next = 1'b1;
                  if (op_reg == OP_ID_ENTER)
                     id_mode_next = 1'b1; // Persists across reads
                  if (op_reg == OP_RESET)
                  begin
                     id_mode_next = 1'b0; // Reset leaves identifier mode
                     err_next = 1'b0; // Reset answers the error flag
                  end
               end
               else
               begin
                  step_next = step_reg + 3'h1;
                  st_next = NF_ISSUE;
               end
            end
         default: st_next = NF_IDLE;
      endcase
   end

   // Register file readback
   always_comb
   begin
      unique case (AVS_ADDRESS_IN)
         REG_CTRL_OFF: rd_mux = {23'h0, tun_reg, 1'b0, op_reg, 4'h0};
         REG_ADDR_OFF: rd_mux = {12'h000, addr_reg};
         REG_DATA_OFF: rd_mux = {16'h0000, rdata_reg};
         REG_STAT_OFF: rd_mux = {28'h0, id_mode_reg, err_reg, done_reg, busy};
         default: rd_mux = 32'h0000_0000;
      endcase
      // Capture on the first read cycle, answer on the second
      rd_ack_next = AVS_READ_IN && !rd_ack_reg;
      rdd_next = AVS_READDATA_OUT;
      if (AVS_READ_IN && !rd_ack_reg)
         rdd_next = rd_mux;
   end

   // Registers
   always_ff @(posedge MCLK_IN)
   begin
      if (RST_IN)
      begin
         st_reg <= NF_IDLE;
         op_reg <= OP_READ;
         step_reg <= 3'h0;
         addr_reg <= 20'h00000;
         data_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
         tun_reg <= 1'b0;
         err_reg <= 1'b0;
         id_mode_reg <= 1'b0;
         done_reg <= 1'b0;
         AVS_READDATA_OUT <= CTRL_RESET;
         rd_ack_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         op_reg <= op_next;
         step_reg <= step_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         rdata_reg <= rdata_next;
         tun_reg <= tun_next;
         err_reg <= err_next;
         id_mode_reg <= id_mode_next;
         done_reg <= done_next;
         AVS_READDATA_OUT <= rdd_next;
         rd_ack_reg <= rd_ack_next;
      end
   end

   // Bus cycle engine
   nfc_cycle u_cycle
   (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .req_valid_in(cyc_valid),
      .req_in(cyc_req),
      .req_ready_out(cyc_ready),
      .done_out(cyc_done),
      .rdata_out(cyc_rdata),
      .pins_out(pins),
      .dq_in(FL_DQ_IN)
   );

   assign FL_CE_N_OUT = pins.ce_n;
   assign FL_WE_N_OUT = pins.we_n;
   assign FL_OE_N_OUT = pins.oe_n;
   assign FL_ADDR_OUT = pins.addr; // Logic levels only, never elevated
   assign FL_DQ_OUT = pins.dq_out;
   assign FL_DQ_OE_OUT = pins.dq_oe;
   assign FL_RESET_N_OUT = 1'b1;
   assign FL_RESET_ELEV_OUT = tun_reg;

   a_busy_stall: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      busy |=> $stable(op_reg))
      else $error("command accepted while a sequence runs");
   a_reset_exit: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (st_reg == NF_WAIT && cyc_done && op_reg == OP_RESET) |=> !id_mode_reg && !err_reg)
      else $error("reset command did not clear modes");
   a_id_entry: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (st_reg == NF_WAIT && cyc_done && op_reg == OP_ID_ENTER && step_reg == 3'h2)
      |=> id_mode_reg && done_reg)
      else $error("identifier mode not recorded");
   a_unlock_first: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (cyc_valid && op_reg == OP_PROGRAM && step_reg == 3'h0)
      |-> cyc_req.data[7:0] == FL_UNLOCK1 && cyc_req.addr == FL_ADDR_555)
      else $error("sequence does not open with first unlock");
   a_elev_follow: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == REG_CTRL_OFF)
      |=> FL_RESET_ELEV_OUT == $past(AVS_WRITEDATA_IN[CTRL_TEMP_UNPROT_BIT]))
      else $error("elevated reset level out of step");
   c_prog: cover property (@(posedge MCLK_IN) disable iff (RST_IN)
      op_reg == OP_PROGRAM && done_reg);
   c_id: cover property (@(posedge MCLK_IN) disable iff (RST_IN) $rose(id_mode_reg));
   c_err: cover property (@(posedge MCLK_IN) disable iff (RST_IN) $rose(err_reg));
endmodule : nfc_ctrl

// >>> nfc_flash_model.sv
// Behavioural flash device answering the controller's bus cycles
`timescale 1ns/100ps
module nfc_flash_model
#(
   parameter logic [15:0] MAKER = 16'h00C3, // Arbitrary value
   parameter logic [15:0] DEVID = 16'h005A // Arbitrary value
)
(
   // Flash pins
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic elev_in,
   input wire logic lockout_in,
   input wire logic [19:0] addr_in,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out
);
   logic [15:0] mem [2048];
   logic [7:0] prot = 8'h00;
   logic [15:0] last = 16'h0000;
   logic [19:0] lat_a = 20'h00000;
   logic armed = 1'b0;
   logic idm = 1'b0;
   logic err = 1'b0;
   int st = 0;
   initial foreach (mem[i]) mem[i] = 16'hFFFF;
   // Array index from sector and low byte
   function automatic int ix(logic [19:0] a);
      return {a[19:17], a[7:0]};
   endfunction : ix
   // One accepted write cycle through the unlock sequencer
   task automatic write_cyc(logic [19:0] a, logic [15:0] d);
      logic ok;
      ok = !prot[a[19:17]] || elev_in;
      if (lockout_in)
         {st, idm, err} = '0;
      else if (d[7:0] == 8'hF0 && st != 3) // Program data cycle takes F0 as data
         {st, idm, err} = '0;
      else if (!idm)
         case (st)
            0, 4: st = (a[10:0] == 11'h555 && d[7:0] == 8'hAA) ? st + 1 : 0;
            1, 5: st = (a[10:0] == 11'h2AA && d[7:0] == 8'h55) ? st + 1 : 0;
            2:
            begin
               idm = (a[10:0] == 11'h555 && d[7:0] == 8'h90);
               st = (a[10:0] != 11'h555) ? 0 : (d[7:0] == 8'hA0) ? 3 : (d[7:0] == 8'h80) ? 4 : 0;
            end
            3:
            begin
               st = 0;
               if (ok && (~mem[ix(a)] & d) != 16'h0000)
                  err = 1'b1;
               else if (ok)
                  mem[ix(a)] = mem[ix(a)] & d;
            end
            6:
            begin
               for (int i = 0; i < 2048; i++)
                  if ((!prot[i[10:8]] || elev_in) &&
                     (d[7:0] == 8'h10 || (d[7:0] == 8'h30 && i[10:8] == a[19:17])))
                     mem[i] = 16'hFFFF;
               st = 0;
            end
            default: st = 0;
         endcase
   endtask : write_cyc
   // Address on the later falling edge, data on the first rising edge
   always @(negedge we_n_in or negedge ce_n_in)
      if (!we_n_in && !ce_n_in && oe_n_in)
      begin
         armed = 1'b1;
         lat_a = addr_in;
      end
   always @(posedge we_n_in or posedge ce_n_in)
      if (armed)
      begin
         armed = 1'b0;
         write_cyc(lat_a, dq_in);
      end
   // Read value, identifier codes on the low lane only
   // No erase suspend here; array reads show status (0020) only while err is set
   function automatic logic [15:0] rv(logic [19:0] a);
      if (idm)
         return (a[1:0] == 2'h0) ? MAKER : (a[1:0] == 2'h1) ? DEVID :
            (a[1:0] == 2'h2) ? {15'h0000, prot[a[19:17]]} : 16'h0000;
      return err ? 16'h0020 : mem[ix(a)];
   endfunction : rv
   always @(negedge oe_n_in or negedge ce_n_in)
      #1 if (!ce_n_in && !oe_n_in) last = rv(addr_in);
   always @(posedge lockout_in)
      {st, idm, err} = '0;
   // Released bus shows the inverse of the last word
   assign dq_out = (!ce_n_in && !oe_n_in) ? last : ~last;
endmodule : nfc_flash_model

// >>> nfc_ctrl_tb_top.sv
// Self-checking bench for the flash command controller
`timescale 1ns/100ps
module nfc_ctrl_tb_top;
   import nfc_pkg::*;
   localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary value
   localparam logic [15:0] DEVID = 16'h005A; // Arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic lko = 1'b0;
   logic tmp = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdv, rdat;
   logic wreq, ce_n, we_n, oe_n, elev, dq_oe;
   logic [19:0] fadr;
   logic [15:0] dq_o, mdq, d;
   wire logic [15:0] dq_bus = dq_oe ? dq_o : mdq;
   int bad_count = 0;
   int num_checks = 0;
   int k;
   logic [15:0] rmem [int];
   logic [7:0] rprot = 8'h00;
   logic [35:0] raws [9] = '{36'h00555_00AA, 36'h002AA_0055, 36'h12345_00F0, 36'h00555_00A0,
      36'hE0000_000F, 36'h00555_00AA, 36'h00123_0055, 36'h00555_00A0, 36'hE0000_0000};
   always #50 clk = ~clk;
   nfc_ctrl nfc_ctrl_i (.MCLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
      .AVS_WAITREQUEST_OUT(wreq), .FL_CE_N_OUT(ce_n), .FL_WE_N_OUT(we_n), .FL_OE_N_OUT(oe_n),
      .FL_RESET_N_OUT(), .FL_RESET_ELEV_OUT(elev), .FL_ADDR_OUT(fadr), .FL_DQ_OUT(dq_o),
      .FL_DQ_OE_OUT(dq_oe), .FL_DQ_IN(dq_bus));
   nfc_flash_model #(.MAKER(MAKER), .DEVID(DEVID)) nfc_flash_model_i (.ce_n_in(ce_n),
      .we_n_in(we_n), .oe_n_in(oe_n), .elev_in(elev), .lockout_in(lko), .addr_in(fadr),
      .dq_in(dq_bus), .dq_out(mdq));
   // Comparisons of flash words and of status flags
   task automatic cmp16(logic [15:0] got, logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask : cmp16
   task automatic cmp_flag(logic got, logic exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t flag got %h exp %h", $time, got, exp);
      end
   endtask : cmp_flag
   // Avalon transfer, held until waitrequest is seen low
   task automatic bus(logic w, logic [3:0] a, logic [31:0] dat);
      @(posedge clk);
      adr <= a;
      wd <= dat;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (wreq !== 1'b0);
      rdv = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   // Start an operation and poll until idle
   task automatic op(logic [2:0] o, logic [19:0] a, logic [15:0] dat);
      bus(1'b1, REG_ADDR_OFF, {12'h000, a});
      bus(1'b1, REG_DATA_OFF, {16'h0000, dat});
      bus(1'b1, REG_CTRL_OFF, {23'h000000, tmp, 1'b0, o, 3'h0, 1'b1});
      do bus(1'b0, REG_STAT_OFF, 32'h0); while (rdv[0] !== 1'b0);
   endtask : op
   task automatic frd(logic [19:0] a, logic [15:0] exp);
      op(OP_READ, a, 16'h0000);
      bus(1'b0, REG_DATA_OFF, 32'h0);
      cmp16(rdv[15:0], exp);
   endtask : frd
   // Reference array keyed by sector and low byte
   function automatic logic [15:0] rget(int j);
      return rmem.exists(j) ? rmem[j] : 16'hFFFF;
   endfunction : rget
   function automatic logic [19:0] fa(int j);
      return {j[10:8], 9'h000, j[7:0]};
   endfunction : fa
   task automatic rprog(int j, logic [15:0] dat);
      if (!rprot[j[10:8]] || tmp)
         rmem[j] = rget(j) & dat;
   endtask : rprog
   task automatic rers(int s);
      foreach (rmem[j])
         if ((s < 0 || j[10:8] == s) && !rprot[j[10:8]])
            rmem[j] = 16'hFFFF;
   endtask : rers
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   // Main sequence
   initial
   begin
      void'($urandom(37571));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, REG_STAT_OFF, 32'h0);
      cmp_flag(rdv[3] | rdv[0], 1'b0);
      cmp_flag(ce_n & we_n & oe_n, 1'b1);
      $display("test reset done");
      op(OP_ID_ENTER, 20'h00000, 16'h0000);
      bus(1'b0, REG_STAT_OFF, 32'h0);
      cmp_flag(rdv[3], 1'b1);
      for (int s = 0; s < 8; s++)
      begin
         frd(ID_MAKER_OFF, MAKER);
         frd({s[2:0], 17'h00000} | ID_PROT_OFF, 16'h0000);
      end
      frd(ID_DEVICE_OFF, DEVID);
      op(OP_RESET, 20'hABCDE, 16'h0000);
      bus(1'b0, REG_STAT_OFF, 32'h0);
      cmp_flag(rdv[3], 1'b0);
      frd(20'h00000, rget(0));
      $display("test identifier done");
      for (int i = 0; i < 6; i++)
      begin
         k = {i[2:0], 8'($urandom)};
         d = 16'($urandom);
         op(OP_PROGRAM, fa(k), d);
         rprog(k, d);
         frd(fa(k), rget(k));
      end
      $display("test program done");
      nfc_flash_model_i.prot[6] = 1'b1;
      rprot[6] = 1'b1;
      op(OP_ID_ENTER, 20'h00000, 16'h0000);
      frd(20'hC0002, 16'h0001);
      op(OP_RESET, 20'h00000, 16'h0000);
      for (int j = 0; j < 3; j++)
      begin
         tmp = (j == 1);
         d = 16'($urandom);
         op(OP_PROGRAM, fa(12'h600 + j), d);
         rprog(12'h600 + j, d);
         frd(fa(12'h600 + j), rget(12'h600 + j));
      end
      tmp = 1'b0;
      op(OP_SECT_ERASE, fa(12'h300), 16'h0000);
      rers(3);
      op(OP_SECT_ERASE, fa(12'h600), 16'h0000);
      rers(6);
      op(OP_CHIP_ERASE, 20'h00000, 16'h0000);
      rers(-1);
      foreach (rmem[j]) frd(fa(j), rget(j));
      $display("test protect done");
      op(OP_PROGRAM, 20'hE0000, 16'h0F0F);
      foreach (raws[i]) op(OP_RAW_WRITE, raws[i][35:16], raws[i][15:0]);
      frd(20'hE0000, 16'h0F0F);
      lko <= 1'b1;
      op(OP_PROGRAM, 20'hE0001, 16'h0000);
      lko <= 1'b0;
      frd(20'hE0001, 16'hFFFF);
      $display("test inhibit done");
      op(OP_PROGRAM, 20'hE0000, 16'hFFFF);
      frd(20'hE0000, 16'h0020);
      bus(1'b0, REG_STAT_OFF, 32'h0);
      cmp_flag(rdv[2], 1'b1);
      op(OP_RESET, 20'h00000, 16'h0000);
      bus(1'b0, REG_STAT_OFF, 32'h0);
      cmp_flag(rdv[2], 1'b0);
      frd(20'hE0000, 16'h0F0F);
      $display("test error done");
      stop_test();
   end
   // Watchdog against a hung handshake
   initial
   begin
      #(100 * 40000);
      bad_count++;
      stop_test();
   end
endmodule : nfc_ctrl_tb_top
